// ==== flash_seq_pkg.sv ====
// Shared constants and types of the flash program and erase sequencer.
// Assumes a 20 MHz bus clock and a 7.37 MHz nominal internal oscillator.
package flash_seq_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_PAGE = 8'h08;
  localparam logic [7:0] OFS_POINTER = 8'h0c;
  localparam logic [7:0] OFS_TBL_LOW = 8'h10;
  localparam logic [7:0] OFS_TBL_HIGH = 8'h14;
  localparam logic [7:0] OFS_TUNE = 8'h18;

  // Control register field positions.
  localparam int START_BIT = 15;
  localparam int ENABLE_BIT = 14;
  localparam int ERROR_BIT = 13;
  localparam int ERASE_BIT = 6;
  localparam int OP_MSB = 3;

  // Reset values.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [5:0] TUNE_RESET = 6'h00;

  // Unlock key bytes.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Operation select codes.
  localparam logic [3:0] OP_BULK = 4'hf;
  localparam logic [3:0] OP_GEN_SEG = 4'hd;
  localparam logic [3:0] OP_SEC_SEG = 4'hc;
  localparam logic [3:0] OP_WORD = 4'h3;
  localparam logic [3:0] OP_PAGE = 4'h2;
  localparam logic [3:0] OP_ROW = 4'h1;
  localparam logic [3:0] OP_CFG = 4'h0;

  // Oscillator rate emulation and operation length.
  localparam int HCLK_KHZ = 20000;
  localparam int OSC_KHZ = 7370;
  localparam int OSC_STEP = OSC_KHZ / 10;
  localparam int OSC_MOD = HCLK_KHZ / 10;
  localparam int TUNE_STEP = 3;
  localparam int ROW_WRITE_OSC_CYCLES = 11064;

  // Page and row alignment of the flash target address.
  localparam logic [23:0] PAGE_ADDR_MASK = 24'hff_fc00;
  localparam logic [23:0] ROW_ADDR_MASK = 24'hff_ff80;
  localparam logic [15:0] POINTER_STEP = 16'h0002;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_FIRST_SEEN = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_type;

  typedef enum logic [0:0] {
    OP_IDLE = 1'b0,
    OP_RUN = 1'b1
  } op_state_type;

  typedef enum logic [3:0] {
    KIND_NONE = 4'b0000,
    KIND_BULK = 4'b0001,
    KIND_GEN_SEG = 4'b0010,
    KIND_SEC_SEG = 4'b0011,
    KIND_PAGE = 4'b0100,
    KIND_CFG_ERASE = 4'b0101,
    KIND_WORD = 4'b0110,
    KIND_ROW = 4'b0111,
    KIND_CFG_PROG = 4'b1000
  } op_kind_type;

endpackage

// ==== hold_buf_if.sv ====
// Interface between the sequencer and its row holding buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface hold_buf_if #(
  parameter int IDX_W = 6,
  parameter int DATA_W = 24
);
  logic wr_lo;
  logic wr_hi;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wdata;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output wr_lo, wr_hi, wr_idx, wdata, rd_idx, input rdata);
  modport buffer (input wr_lo, wr_hi, wr_idx, wdata, rd_idx, output rdata);
endinterface

// ==== frc_tick_gen.sv ====
// Fractional divider that emits one-cycle pulses at the oscillator rate.
// Assumes the bus clock rate named in the package; tune is two's complement.
`timescale 1ns/1ns
module osc_tick_gen (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic [5:0] osc_tune,
  // Rate pulse
  output logic tick
);
  typedef struct packed {
    logic [11:0] acc;
    logic tick;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [12:0] inc;
  logic [12:0] sum;

  always_comb begin
    inc = 13'(flash_seq_pkg::OSC_STEP +
              flash_seq_pkg::TUNE_STEP * $signed(osc_tune));
    sum = {1'b0, s_q.acc} + inc;
    s_d = s_q;
    s_d.tick = 1'b0;
    if (sum >= 13'(flash_seq_pkg::OSC_MOD)) begin
      s_d.acc = 12'(sum - 13'(flash_seq_pkg::OSC_MOD));
      s_d.tick = 1'b1;
    end else begin
      s_d.acc = sum[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ==== row_hold_buffer.sv ====
// Row holding buffer: one entry per instruction, low and high lanes apart.
// Assumes writes and reads are indexed by the sequencer.
`timescale 1ns/1ns
module row_hold_buffer #(
  parameter int DEPTH = 64,
  parameter int DATA_W = 24
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer side
  hold_buf_if.buffer hb
);
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  always_comb begin
    s_d = s_q;
    if (hb.wr_lo) begin
      s_d.mem[hb.wr_idx][15:0] = hb.wdata[15:0];
    end
    if (hb.wr_hi) begin
      s_d.mem[hb.wr_idx][DATA_W-1:16] = hb.wdata[DATA_W-1:16];
    end
    s_d.rdata = s_q.mem[hb.rd_idx];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hb.rdata = s_q.rdata;
endmodule

// ==== flash_program_erase_sequencer.sv ====
// Flash program and erase sequencer with an AHB-Lite register slave.
// Assumes hresetn is the power-on reset and warm_reset any other source.
// Notes on behaviour
// RULE1: Core is stalled from operation start until it completes.
// RULE2: Operations are timed by ticks of the emulated internal oscillator.
// RULE3: Row write lasts 11064 oscillator ticks.
// RULE4: Start bit 15 launches the operation; hardware clears it at the end.
// RULE5: Software can only set start; writing zero does nothing.
// RULE6: Enable bit 14 permits operations; zero blocks them.
// RULE7: Error bit 13 flags improper starts or aborts, not normal ends.
// RULE8: Erase bit 6 chooses erase or program meaning of the op field.
// RULE9: Erase codes: f bulk, d general, c secure, 2 page, 0 config byte.
// RULE10: Program codes: 3 word, 1 row, 0 config byte.
// RULE11: Any other op code starts no flash activity.
// RULE12: Control bits reset only at power-on, not by other resets.
// RULE13: Software writes 55 then aa to the key register before start.
// RULE14: Key register takes the low byte only and reads as zero.
// RULE15: Page erase covers 512 instructions, row program 64.
// RULE16: Page erase flow: op 2, erase, enable, address, keys, start.
// RULE17: Row flow: fill buffers, op 1, program, enable, keys, start.
// RULE18: Software puts two no-operations after setting start.
// RULE19: Holding buffers hold 64 instructions loaded by table writes.
// RULE20: Target address is table page byte joined with the pointer.
// RULE21: Start without a fresh key pair sets error and starts nothing.
`timescale 1ns/1ns
module flash_program_erase_sequencer #(
  parameter logic [15:0] ROW_OSC_CYCLES = 16'(
    flash_seq_pkg::ROW_WRITE_OSC_CYCLES),
  parameter logic [15:0] ERASE_OSC_CYCLES = 16'h2b38,
  parameter logic [15:0] WORD_OSC_CYCLES = 16'h0400
) (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // Other reset sources
  input wire logic warm_reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Core and flash array
  output logic cpu_stall,
  output logic flash_busy,
  output logic [3:0] flash_op,
  output logic [23:0] flash_addr,
  output logic [23:0] flash_wdata,
  output logic flash_done
);
  typedef struct packed {
    logic pend;
    logic pend_wr;
    logic [7:0] addr;
    logic start;
    logic enable;
    logic error;
    logic erase;
    logic [3:0] op;
    logic [7:0] page;
    logic [15:0] ptr;
    logic [5:0] tune;
    flash_seq_pkg::key_state_type key;
    flash_seq_pkg::op_state_type run;
    flash_seq_pkg::op_kind_type kind;
    logic [15:0] count;
    logic [23:0] faddr;
    logic [5:0] row_idx;
    logic done;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic tick;
  logic wr_now;
  logic [23:0] target;
  flash_seq_pkg::op_kind_type new_kind;

  hold_buf_if #(.IDX_W(6), .DATA_W(24)) hb ();

  // RULE8 erase select
  // RULE9 erase decode
  // RULE10 program decode
  // RULE11 unimplemented codes
  function automatic flash_seq_pkg::op_kind_type op_decode(
    input logic erase,
    input logic [3:0] code
  );
    op_decode = flash_seq_pkg::KIND_NONE;
    if (erase) begin
      case (code)
        flash_seq_pkg::OP_BULK: op_decode = flash_seq_pkg::KIND_BULK;
        flash_seq_pkg::OP_GEN_SEG: op_decode = flash_seq_pkg::KIND_GEN_SEG;
        flash_seq_pkg::OP_SEC_SEG: op_decode = flash_seq_pkg::KIND_SEC_SEG;
        flash_seq_pkg::OP_PAGE: op_decode = flash_seq_pkg::KIND_PAGE;
        flash_seq_pkg::OP_CFG: op_decode = flash_seq_pkg::KIND_CFG_ERASE;
        default: op_decode = flash_seq_pkg::KIND_NONE;
      endcase
    end else begin
      case (code)
        flash_seq_pkg::OP_WORD: op_decode = flash_seq_pkg::KIND_WORD;
        flash_seq_pkg::OP_ROW: op_decode = flash_seq_pkg::KIND_ROW;
        flash_seq_pkg::OP_CFG: op_decode = flash_seq_pkg::KIND_CFG_PROG;
        default: op_decode = flash_seq_pkg::KIND_NONE;
      endcase
    end
  endfunction

  // RULE3 row write length
  function automatic logic [15:0] op_length(
    input flash_seq_pkg::op_kind_type kind
  );
    op_length = ERASE_OSC_CYCLES;
    if (kind == flash_seq_pkg::KIND_ROW) begin
      op_length = ROW_OSC_CYCLES;
    end else if (kind == flash_seq_pkg::KIND_WORD ||
                 kind == flash_seq_pkg::KIND_CFG_PROG) begin
      op_length = WORD_OSC_CYCLES;
    end
  endfunction

  // RULE14 key reads zero
  function automatic logic [31:0] read_value(input state_type s);
    logic [15:0] ctrl;
    ctrl = flash_seq_pkg::CONTROL_RESET;
    read_value = 32'h0000_0000;
    ctrl[flash_seq_pkg::START_BIT] = s.start;
    ctrl[flash_seq_pkg::ENABLE_BIT] = s.enable;
    ctrl[flash_seq_pkg::ERROR_BIT] = s.error;
    ctrl[flash_seq_pkg::ERASE_BIT] = s.erase;
    ctrl[flash_seq_pkg::OP_MSB:0] = s.op;
    if (s.addr == flash_seq_pkg::OFS_CONTROL) begin
      read_value = {16'h0000, ctrl};
    end else if (s.addr == flash_seq_pkg::OFS_PAGE) begin
      read_value = {24'h00_0000, s.page};
    end else if (s.addr == flash_seq_pkg::OFS_POINTER) begin
      read_value = {16'h0000, s.ptr};
    end else if (s.addr == flash_seq_pkg::OFS_TUNE) begin
      read_value = {26'h000_0000, s.tune};
    end
  endfunction

  // RULE2 oscillator timing
  osc_tick_gen u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_tune(s_q.tune),
    .tick(tick)
  );

  // RULE19 holding buffers
  row_hold_buffer #(.DEPTH(64), .DATA_W(24)) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .hb(hb)
  );

  // RULE1 core stall
  assign hreadyout = !(s_q.pend && s_q.run == flash_seq_pkg::OP_RUN);
  assign hresp = 1'b0;
  assign wr_now = s_q.pend && s_q.pend_wr && hreadyout;
  assign hrdata = (s_q.pend && !s_q.pend_wr) ? read_value(s_q) :
                  32'h0000_0000;
  // RULE20 target address
  assign target = {s_q.page, s_q.ptr};
  assign new_kind = op_decode(hwdata[flash_seq_pkg::ERASE_BIT],
                              hwdata[flash_seq_pkg::OP_MSB:0]);

  assign hb.wr_lo = wr_now && s_q.addr == flash_seq_pkg::OFS_TBL_LOW;
  assign hb.wr_hi = wr_now && s_q.addr == flash_seq_pkg::OFS_TBL_HIGH;
  assign hb.wr_idx = s_q.ptr[6:1];
  assign hb.wdata = hb.wr_hi ? {hwdata[7:0], 16'h0000} :
                    {8'h00, hwdata[15:0]};
  assign hb.rd_idx = (s_q.kind == flash_seq_pkg::KIND_ROW) ? s_q.row_idx :
                     s_q.ptr[6:1];

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_d.pend = 1'b1;
      s_d.pend_wr = hwrite && hsize == flash_seq_pkg::HSIZE_WORD;
      s_d.addr = haddr[7:0];
    end else if (hreadyout) begin
      s_d.pend = 1'b0;
    end
    if (wr_now) begin
      if (s_q.addr != flash_seq_pkg::OFS_KEY) begin
        s_d.key = flash_seq_pkg::KEY_IDLE;
      end
      if (s_q.addr == flash_seq_pkg::OFS_CONTROL) begin
        s_d.enable = hwdata[flash_seq_pkg::ENABLE_BIT];
        s_d.error = hwdata[flash_seq_pkg::ERROR_BIT];
        s_d.erase = hwdata[flash_seq_pkg::ERASE_BIT];
        s_d.op = hwdata[flash_seq_pkg::OP_MSB:0];
        // RULE5 set only start
        if (hwdata[flash_seq_pkg::START_BIT]) begin
          // RULE21 improper start
          // RULE6 enable gate
          if (s_q.key != flash_seq_pkg::KEY_ARMED || warm_reset ||
              !hwdata[flash_seq_pkg::ENABLE_BIT]) begin
            // RULE7 error set wins
            s_d.error = 1'b1;
          end else if (new_kind != flash_seq_pkg::KIND_NONE) begin
            // RULE4 launch
            s_d.start = 1'b1;
            s_d.run = flash_seq_pkg::OP_RUN;
            s_d.kind = new_kind;
            s_d.count = op_length(new_kind) - 16'h0001;
            s_d.row_idx = 6'h00;
            // RULE15 page and row spans
            if (new_kind == flash_seq_pkg::KIND_PAGE) begin
              s_d.faddr = target & flash_seq_pkg::PAGE_ADDR_MASK;
            end else if (new_kind == flash_seq_pkg::KIND_ROW) begin
              s_d.faddr = target & flash_seq_pkg::ROW_ADDR_MASK;
            end else begin
              s_d.faddr = target;
            end
          end
        end
      end else if (s_q.addr == flash_seq_pkg::OFS_KEY) begin
        // RULE13 consecutive key pair
        if (hwdata[7:0] == flash_seq_pkg::KEY_FIRST) begin
          s_d.key = flash_seq_pkg::KEY_FIRST_SEEN;
        end else if (s_q.key == flash_seq_pkg::KEY_FIRST_SEEN &&
                     hwdata[7:0] == flash_seq_pkg::KEY_SECOND) begin
          s_d.key = flash_seq_pkg::KEY_ARMED;
        end else begin
          s_d.key = flash_seq_pkg::KEY_IDLE;
        end
      end else if (s_q.addr == flash_seq_pkg::OFS_PAGE) begin
        s_d.page = hwdata[7:0];
      end else if (s_q.addr == flash_seq_pkg::OFS_POINTER) begin
        s_d.ptr = hwdata[15:0];
      end else if (s_q.addr == flash_seq_pkg::OFS_TBL_HIGH) begin
        s_d.ptr = s_q.ptr + flash_seq_pkg::POINTER_STEP;
      end else if (s_q.addr == flash_seq_pkg::OFS_TUNE) begin
        s_d.tune = hwdata[5:0];
      end
    end
    case (s_q.run)
      flash_seq_pkg::OP_IDLE: begin
      end
      flash_seq_pkg::OP_RUN: begin
        if (warm_reset) begin
          s_d.error = 1'b1;
          s_d.start = 1'b0;
          s_d.run = flash_seq_pkg::OP_IDLE;
        end else if (tick) begin
          s_d.row_idx = s_q.row_idx + 6'h01;
          if (s_q.count == 16'h0000) begin
            // RULE4 hardware clear
            s_d.start = 1'b0;
            s_d.run = flash_seq_pkg::OP_IDLE;
            s_d.done = 1'b1;
          end else begin
            s_d.count = s_q.count - 16'h0001;
          end
        end
      end
      default: s_d.run = flash_seq_pkg::OP_IDLE;
    endcase
    // RULE12 warm reset spares control
    if (warm_reset) begin
      s_d.key = flash_seq_pkg::KEY_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.start <= flash_seq_pkg::CONTROL_RESET[flash_seq_pkg::START_BIT];
      s_q.page <= flash_seq_pkg::PAGE_RESET;
      s_q.ptr <= flash_seq_pkg::POINTER_RESET;
      s_q.tune <= flash_seq_pkg::TUNE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_stall = s_q.run == flash_seq_pkg::OP_RUN;
  assign flash_busy = s_q.run == flash_seq_pkg::OP_RUN;
  assign flash_op = s_q.kind;
  assign flash_addr = s_q.faddr;
  assign flash_wdata = hb.rdata;
  assign flash_done = s_q.done;

  // Ticks seen during the running operation, for the length check.
  logic [15:0] ticks_seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ticks_seen_q <= 16'h0000;
    end else if (s_q.run == flash_seq_pkg::OP_IDLE) begin
      ticks_seen_q <= 16'h0000;
    end else if (tick) begin
      ticks_seen_q <= ticks_seen_q + 16'h0001;
    end
  end

  a_stall_on_run: assert property ( // RULE1
    @(posedge hclk) disable iff (!hresetn)
    (s_q.run == flash_seq_pkg::OP_RUN && s_q.pend) |-> !hreadyout)
    else $error("bus access not stalled during operation");

  a_row_length: assert property ( // RULE3
    @(posedge hclk) disable iff (!hresetn)
    (s_q.done && s_q.kind == flash_seq_pkg::KIND_ROW) |->
    ($past(ticks_seen_q) + 16'h0001 == ROW_OSC_CYCLES))
    else $error("row write length wrong");

  a_start_launch: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    $rose(flash_busy) |-> s_q.start ##0 (s_q.start throughout
    flash_busy[*1]))
    else $error("start bit not set at launch");

  a_start_clear: assert property ( // RULE5
    @(posedge hclk) disable iff (!hresetn)
    $fell(s_q.start) |-> ($past(flash_busy) && !flash_busy &&
    ($past(tick) || $past(warm_reset))))
    else $error("start bit cleared by other than hardware");

  a_enable_gate: assert property ( // RULE6
    @(posedge hclk) disable iff (!hresetn)
    $rose(flash_busy) |-> s_q.enable)
    else $error("operation started while disabled");

  a_error_normal: assert property ( // RULE7
    @(posedge hclk) disable iff (!hresetn)
    s_q.done |-> s_q.error == $past(s_q.error))
    else $error("error flag changed at normal completion");

  a_error_abort: assert property ( // RULE7
    @(posedge hclk) disable iff (!hresetn)
    (flash_busy && warm_reset) |=> (s_q.error && !flash_busy))
    else $error("abort did not flag error");

  a_known_kind: assert property ( // RULE11
    @(posedge hclk) disable iff (!hresetn)
    $rose(flash_busy) |-> flash_op != flash_seq_pkg::KIND_NONE)
    else $error("unimplemented code started an operation");

  a_key_armed: assert property ( // RULE21
    @(posedge hclk) disable iff (!hresetn)
    $rose(flash_busy) |-> $past(s_q.key) == flash_seq_pkg::KEY_ARMED)
    else $error("operation started without key pair");

  a_key_read_zero: assert property ( // RULE14
    @(posedge hclk) disable iff (!hresetn)
    (s_q.pend && !s_q.pend_wr && s_q.addr == flash_seq_pkg::OFS_KEY) |->
    hrdata == 32'h0000_0000)
    else $error("key register read not zero");

  a_warm_keeps: assert property ( // RULE12
    @(posedge hclk) disable iff (!hresetn)
    (warm_reset && !flash_busy && !wr_now) |=>
    (s_q.enable == $past(s_q.enable) && s_q.op == $past(s_q.op) &&
    s_q.erase == $past(s_q.erase)))
    else $error("warm reset changed control bits");

endmodule

// ==== core_bus_model.sv ====
// Processor core model: single word register transfers on AHB-Lite.
// Assumes the one slave's hreadyout is wired back as the bus hready.
`timescale 1ns/1ns
module core_bus_model (
  // Clock
  input wire logic hclk,
  // Slave answer
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = flash_seq_pkg::HSIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // Entered just after a rising edge; ok drops when no answer comes.
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic ok);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    hwdata <= ~hwdata;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 2000);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 2000);
    r = hrdata;
    ok = (n < 2000);
  endtask

  task automatic start_op(input logic [31:0] ctl, output logic ok);
    logic [31:0] r;
    logic ok1;
    logic ok2;
    xfer(1'b1, flash_seq_pkg::OFS_KEY,
        {24'h00_0000, flash_seq_pkg::KEY_FIRST}, r, ok1);
    xfer(1'b1, flash_seq_pkg::OFS_KEY,
        {24'h00_0000, flash_seq_pkg::KEY_SECOND}, r, ok2);
    xfer(1'b1, flash_seq_pkg::OFS_CONTROL, ctl, r, ok);
    ok = ok & ok1 & ok2;
    repeat (2) @(posedge hclk);
  endtask
endmodule

// ==== test_flash_program_erase_sequencer.sv ====
// Testbench of the flash program and erase sequencer.
// Assumes the core model drives the bus; operation counts are shortened.
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module test_flash_program_erase_sequencer;
  logic hclk;
  logic hresetn;
  logic warm_reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic cpu_stall;
  logic flash_busy;
  logic [3:0] flash_op;
  logic [23:0] flash_addr;
  logic [23:0] flash_wdata;
  logic flash_done;
  logic [31:0] rdv;
  logic ok;
  int errors = 0;
  int n_compared = 0;
  localparam logic [31:0] ZERO = 32'h0000_0000;

  flash_program_erase_sequencer #(.ROW_OSC_CYCLES(16'h0008),
    .ERASE_OSC_CYCLES(16'h0006), .WORD_OSC_CYCLES(16'h0004))
  i_flash_program_erase_sequencer (.hclk(hclk), .hresetn(hresetn),
    .warm_reset(warm_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cpu_stall(cpu_stall), .flash_busy(flash_busy), .flash_op(flash_op),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_done(flash_done));

  core_bus_model i_core_bus_model (.hclk(hclk), .hreadyout(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  always #25 hclk = ~hclk;

  task automatic finish_test();
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    i_core_bus_model.xfer(w, a, d, rdv, ok);
    if (ok !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic start(input logic [31:0] ctl);
    i_core_bus_model.start_op(ctl, ok);
    if (ok !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    while (cpu_stall === 1'b1) begin
      @(posedge hclk);
      #1;
      n++;
      if (n > 500) begin
        errors++;
        finish_test();
      end
    end
  endtask

  function automatic logic [3:0] exp_kind(input logic e,
      input logic [3:0] c);
    if (e) begin
      case (c)
        4'hf: return flash_seq_pkg::KIND_BULK;
        4'hd: return flash_seq_pkg::KIND_GEN_SEG;
        4'hc: return flash_seq_pkg::KIND_SEC_SEG;
        4'h2: return flash_seq_pkg::KIND_PAGE;
        4'h0: return flash_seq_pkg::KIND_CFG_ERASE;
        default: return flash_seq_pkg::KIND_NONE;
      endcase
    end
    case (c)
      4'h3: return flash_seq_pkg::KIND_WORD;
      4'h1: return flash_seq_pkg::KIND_ROW;
      4'h0: return flash_seq_pkg::KIND_CFG_PROG;
      default: return flash_seq_pkg::KIND_NONE;
    endcase
  endfunction

  task automatic t_reset();
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, ZERO)
    bus(1'b0, 8'h1c, ZERO);
    `CHECK(rdv, ZERO)
    `CHECK(hresp, 1'b0)
    bus(1'b1, flash_seq_pkg::OFS_TUNE, 32'hffff_ffff);
    bus(1'b0, flash_seq_pkg::OFS_TUNE, ZERO);
    `CHECK(rdv, 32'h0000_003f)
  endtask

  task automatic t_key();
    bus(1'b1, flash_seq_pkg::OFS_KEY, 32'h1234_5655);
    bus(1'b0, flash_seq_pkg::OFS_KEY, ZERO);
    `CHECK(rdv, ZERO)
    bus(1'b1, flash_seq_pkg::OFS_PAGE, ZERO);
    bus(1'b1, flash_seq_pkg::OFS_KEY, 32'h0000_00aa);
    bus(1'b1, flash_seq_pkg::OFS_CONTROL, 32'h0000_c001);
    #1;
    `CHECK(cpu_stall, 1'b0)
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, 32'h0000_6001)
    start(32'h0000_8001);
    `CHECK(cpu_stall, 1'b0)
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, 32'h0000_2001)
  endtask

  task automatic t_row();
    int n;
    bus(1'b1, flash_seq_pkg::OFS_POINTER, 32'h0000_0100);
    bus(1'b1, flash_seq_pkg::OFS_TBL_LOW, 32'h0000_1111);
    bus(1'b1, flash_seq_pkg::OFS_TBL_HIGH, 32'h0000_0022);
    bus(1'b1, flash_seq_pkg::OFS_TBL_LOW, 32'h0000_3333);
    bus(1'b1, flash_seq_pkg::OFS_TBL_HIGH, 32'h0000_0044);
    bus(1'b0, flash_seq_pkg::OFS_POINTER, ZERO);
    `CHECK(rdv, 32'h0000_0104)
    bus(1'b1, flash_seq_pkg::OFS_POINTER, 32'h0000_0102);
    @(posedge hclk);
    #1;
    `CHECK(flash_wdata, 24'h44_3333)
    start(32'h0000_c001);
    `CHECK(cpu_stall, 1'b1)
    `CHECK(flash_busy, 1'b1)
    `CHECK(flash_op, flash_seq_pkg::KIND_ROW)
    `CHECK(flash_addr, 24'h00_0100)
    wait_idle(n);
    `CHECK(flash_done, 1'b1)
    `CHECK(n inside {[16:22]}, 1'b1)
    @(posedge hclk);
    #1;
    `CHECK(flash_done, 1'b0)
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, 32'h0000_4001)
    bus(1'b1, flash_seq_pkg::OFS_PAGE, 32'h0000_0012);
    bus(1'b1, flash_seq_pkg::OFS_POINTER, 32'h0000_0456);
    start(32'h0000_c042);
    `CHECK(flash_op, flash_seq_pkg::KIND_PAGE)
    `CHECK(flash_addr, 24'h12_0400)
    wait_idle(n);
  endtask

  task automatic t_codes();
    logic [3:0] k;
    logic [31:0] ctl;
    for (int i = 0; i < 32; i++) begin
      k = exp_kind(i[4], i[3:0]);
      ctl = 32'h0000_c000 | {25'h0, i[4], 2'h0, i[3:0]};
      start(ctl);
      `CHECK(cpu_stall, k != flash_seq_pkg::KIND_NONE)
      if (k != flash_seq_pkg::KIND_NONE) begin
        `CHECK(flash_op, k)
      end
      bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
      `CHECK(rdv, ctl & 32'h0000_7fff)
    end
  endtask

  task automatic t_abort();
    start(32'h0000_c001);
    warm_reset <= 1'b1;
    @(posedge hclk);
    warm_reset <= 1'b0;
    @(posedge hclk);
    #1;
    `CHECK(cpu_stall, 1'b0)
    `CHECK(flash_done, 1'b0)
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, 32'h0000_6001)
    warm_reset <= 1'b1;
    @(posedge hclk);
    warm_reset <= 1'b0;
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, 32'h0000_6001)
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, flash_seq_pkg::OFS_CONTROL, ZERO);
    `CHECK(rdv, ZERO)
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    warm_reset = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_key();
    t_row();
    t_codes();
    t_abort();
    finish_test();
  end
endmodule
